// ===== logic/ufat_pkg.sv
// Purpose: constants and types for the user flash access sequencer
// Assumes: 100 MHz clk, flash macro driven directly by registered outputs
// Notes:   times kept in their printed unit, cycle counts derived from them
// Behaviour
// - addresses and enables valid, then sense strobe
// - hold address and enables for access time
// - never program an address twice unerased
// - write-to-erase interval within data storage time; not enforced, only flagged on hv_overrun
// - storage enable setup and hold around operation
// - wait wake-up time after power-down exit
package ufat_pkg;
   localparam int CLK_MHZ     = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_ACC_NS    = 25;    // worst mode
   localparam int T_ADS_NS    = 20;
   localparam int T_PWS_NS    = 5;
   localparam int T_NVS_US    = 5;
   localparam int T_NVH_US    = 5;
   localparam int T_NVH1_US   = 100;
   localparam int T_PGS_US    = 10;
   localparam int T_PROG_US   = 12;    // inside 8..16
   localparam int T_RCV_US    = 10;
   localparam int T_ERASE_MS  = 110;   // inside 100..120
   localparam int T_WK_US     = 7;
   localparam int T_HV_MS     = 6;
   function automatic int ns_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int ACC_CYC   = ns_cyc(T_ACC_NS);
   localparam int ADS_CYC   = ns_cyc(T_ADS_NS);
   localparam int PWS_CYC   = ns_cyc(T_PWS_NS);
   localparam int NVS_CYC   = T_NVS_US * CLK_MHZ;
   localparam int NVH_CYC   = T_NVH_US * CLK_MHZ;
   localparam int NVH1_CYC  = T_NVH1_US * CLK_MHZ;
   localparam int PGS_CYC   = T_PGS_US * CLK_MHZ;
   localparam int PROG_CYC  = T_PROG_US * CLK_MHZ;
   localparam int RCV_CYC   = T_RCV_US * CLK_MHZ;
   localparam int WK_CYC    = T_WK_US * CLK_MHZ;
   localparam int ERASE_CYC = T_ERASE_MS * 1000 * CLK_MHZ;
   localparam int HV_CYC    = T_HV_MS * 1000 * CLK_MHZ;
   localparam int ROW_W = 9;
   localparam int COL_W = 6;
   localparam int DAT_W = 32;
   localparam logic [1:0] OP_READ  = 2'h0;
   localparam logic [1:0] OP_PROG  = 2'h1;
   localparam logic [1:0] OP_PAGE  = 2'h2;
   localparam logic [1:0] OP_MASS  = 2'h3;
   typedef struct packed {
      logic [1:0]       op;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
      logic [DAT_W-1:0] wdata;
   } ufat_req_t;
   typedef struct packed {
      logic [ROW_W-1:0] row_address;
      logic [COL_W-1:0] column_address;
      logic             row_enable;
      logic             column_enable;
      logic             sense_strobe;
      logic             prog_enable;
      logic             erase_enable;
      logic             storage_enable;
      logic             power_down;
      logic [DAT_W-1:0] din;
   } ufat_pins_t;
   typedef enum logic [3:0] {
      ST_WAKE  = 4'h0,
      ST_IDLE  = 4'h1,
      ST_RSET  = 4'h2,
      ST_RSTB  = 4'h3,
      ST_RHOLD = 4'h4,
      ST_NVS   = 4'h5,
      ST_PGS   = 4'h6,
      ST_PULSE = 4'h7,
      ST_NVH   = 4'h8,
      ST_RCV   = 4'h9
   } ufat_state_t;
endpackage

// ===== logic/ufat_ctrl.sv
// Purpose: host-side sequencer driving the user flash macro pins
// Assumes: one request at a time, taken on req_valid while req_ready
// Notes:   written-word map blocks a second program before erase
`timescale 1ns/1ps
`default_nettype none
module ufat_ctrl #(
   parameter int ERASE_CYCLES = ufat_pkg::ERASE_CYC,
   parameter int HV_CYCLES    = ufat_pkg::HV_CYC
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      wake,
   input  wire logic                      req_valid,
   input  wire ufat_pkg::ufat_req_t       req,
   output logic                           req_ready,
   output logic                           done,
   output logic                           refused,
   output logic                           hv_overrun,
   output logic [ufat_pkg::DAT_W-1:0]     rdata,
   output ufat_pkg::ufat_pins_t           pins,
   input  wire logic [ufat_pkg::DAT_W-1:0] flash_dout
);
   import ufat_pkg::*;
   localparam int WORDS = 1 << (ROW_W + COL_W);
   localparam int CW    = 32;

   ufat_state_t            state_reg;
   logic [CW-1:0]          cnt_reg;
   logic [1:0]             op_reg;
   logic [WORDS-1:0]       written_reg;
   logic [CW-1:0]          hv_cnt_reg;
   logic                   hv_run_reg;
   logic                   busy_prog;
   logic [ROW_W+COL_W-1:0] addr;

   assign addr      = {req.row, req.col};
   assign busy_prog = (req.op == OP_PROG) && written_reg[addr];

   // sequence and pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_WAKE;
         cnt_reg   <= '0;
         op_reg    <= OP_READ;
         pins      <= '0;
         rdata     <= '0;
         req_ready <= 1'b0;
         done      <= 1'b0;
         refused   <= 1'b0;
      end else begin
         done    <= 1'b0;
         refused <= 1'b0;
         if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
         if (wake) begin
            pins.power_down <= 1'b0;
         end
         unique case (state_reg)
            ST_WAKE: begin
               // op_reg marks the wake-up wait as started; the wake pin only ends power-down
               if (cnt_reg == '0 && !pins.power_down) begin
                  if (op_reg == OP_PAGE) begin
                     op_reg    <= OP_READ;
                     state_reg <= ST_IDLE;
                     req_ready <= 1'b1;
                  end else begin
                     cnt_reg <= CW'(WK_CYC - 1);
                     op_reg  <= OP_PAGE;
                  end
               end
            end
            ST_IDLE: begin
               if (req_valid) begin
                  if (busy_prog) begin
                     refused <= 1'b1;
                  end else begin
                     req_ready           <= 1'b0;
                     op_reg              <= req.op;
                     pins.row_address    <= req.row;
                     pins.column_address <= req.col;
                     pins.din            <= req.wdata;
                     pins.row_enable     <= 1'b1;
                     pins.column_enable  <= (req.op == OP_READ || req.op == OP_PROG);
                     if (req.op == OP_READ) begin
                        cnt_reg   <= CW'(ADS_CYC - 1);
                        state_reg <= ST_RSET;
                     end else begin
                        pins.prog_enable  <= (req.op == OP_PROG);
                        pins.erase_enable <= (req.op != OP_PROG);
                        cnt_reg   <= CW'(NVS_CYC - 1);
                        state_reg <= ST_NVS;
                     end
                  end
               end
            end
            ST_RSET: if (cnt_reg == '0) begin
               pins.sense_strobe <= 1'b1;
               cnt_reg   <= CW'((ACC_CYC > PWS_CYC ? ACC_CYC : PWS_CYC) - 1);
               state_reg <= ST_RSTB;
            end
            ST_RSTB: if (cnt_reg == '0) begin
               // address and enables still stable here
               pins.sense_strobe <= 1'b0;
               rdata     <= flash_dout;
               state_reg <= ST_RHOLD;
            end
            ST_RHOLD: begin
               pins.row_enable    <= 1'b0;
               pins.column_enable <= 1'b0;
               done      <= 1'b1;
               req_ready <= 1'b1;
               state_reg <= ST_IDLE;
            end
            ST_NVS: if (cnt_reg == '0) begin
               pins.storage_enable <= 1'b1;
               cnt_reg   <= CW'(PGS_CYC - 1);
               state_reg <= ST_PGS;
            end
            ST_PGS: if (cnt_reg == '0) begin
               if (op_reg == OP_PROG) begin
                  pins.sense_strobe <= 1'b1;
                  cnt_reg <= CW'(PROG_CYC - 1);
               end else begin
                  cnt_reg <= CW'(ERASE_CYCLES - 1);
               end
               state_reg <= ST_PULSE;
            end
            ST_PULSE: if (cnt_reg == '0) begin
               pins.sense_strobe <= 1'b0;
               pins.prog_enable  <= 1'b0;
               pins.erase_enable <= 1'b0;
               cnt_reg   <= CW'((op_reg == OP_MASS ? NVH1_CYC : NVH_CYC) - 1);
               state_reg <= ST_NVH;
            end
            ST_NVH: if (cnt_reg == '0) begin
               pins.storage_enable <= 1'b0;
               pins.row_enable     <= 1'b0;
               pins.column_enable  <= 1'b0;
               cnt_reg   <= CW'(RCV_CYC - 1);
               state_reg <= ST_RCV;
            end
            ST_RCV: if (cnt_reg == '0) begin
               done      <= 1'b1;
               req_ready <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_WAKE;
         endcase
      end
   end

   // written-word map, cleared by erase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         written_reg <= '0;
      end else if (state_reg == ST_IDLE && req_valid && !busy_prog) begin
         if (req.op == OP_PROG) begin
            written_reg[addr] <= 1'b1;
         end else if (req.op == OP_MASS) begin
            written_reg <= '0;
         end else if (req.op == OP_PAGE) begin
            for (int c = 0; c < (1 << COL_W); c++) begin
               written_reg[{req.row, COL_W'(c)}] <= 1'b0;
            end
         end
      end
   end

   // age of first write since last mass erase; page erase does not restart it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hv_run_reg <= 1'b0;
         hv_cnt_reg <= '0;
         hv_overrun <= 1'b0;
      end else begin
         if (state_reg == ST_IDLE && req_valid && !busy_prog && req.op == OP_MASS) begin
            hv_run_reg <= 1'b0;
            hv_cnt_reg <= '0;
            // a first overrun in the same cycle wins over the clear
            hv_overrun <= hv_run_reg && !hv_overrun && (hv_cnt_reg >= CW'(HV_CYCLES));
         end else if (state_reg == ST_IDLE && req_valid && !busy_prog
                      && req.op == OP_PROG && !hv_run_reg) begin
            hv_run_reg <= 1'b1;
         end else if (hv_run_reg) begin
            if (hv_cnt_reg >= CW'(HV_CYCLES)) begin
               hv_overrun <= 1'b1;
            end else begin
               hv_cnt_reg <= hv_cnt_reg + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/ufat_flash_model.sv
// Purpose: behavioural user flash array answering the sequencer pins
// Assumes: clockless macro, erased words read all ones
// Notes:   mass erase told apart from page erase by storage hold length
`timescale 1ns/1ps
`default_nettype none
module ufat_flash_model (
   input  wire ufat_pkg::ufat_pins_t      pins,
   output logic [ufat_pkg::DAT_W-1:0]    dout
);
   import ufat_pkg::*;
   logic [DAT_W-1:0] mem [int];
   logic [ROW_W-1:0] erow;
   logic             was_er;
   realtime          t_off;
   initial begin
      dout = 32'h0;
      was_er = 1'b0;
   end
   // program strobe captures while prog and storage enables still stand
   always @(posedge pins.sense_strobe) begin
      if (pins.prog_enable && pins.storage_enable) begin
         mem[{pins.row_address, pins.column_address}] = pins.din;
      end else if (pins.row_enable && pins.column_enable) begin
         dout = ~dout;
         #(T_ACC_NS);
         dout = mem.exists({pins.row_address, pins.column_address}) ?
                mem[{pins.row_address, pins.column_address}] : 32'hFFFFFFFF;
      end
   end
   always @(posedge pins.prog_enable) was_er = 1'b0;
   always @(negedge pins.erase_enable) begin
      was_er = 1'b1;
      erow = pins.row_address;
      t_off = $realtime;
   end
   always @(negedge pins.storage_enable) begin
      if (was_er && $realtime - t_off >= T_NVH1_US * 1000)
         mem.delete();
      else if (was_er)
         for (int c = 0; c < 64; c++)
            mem.delete({erow, c[COL_W-1:0]});
   end
endmodule
`default_nettype wire

// ===== tb/ufat_ctrl_assertions.sv
// Purpose: pin timing checks on the flash sequencer
// Assumes: 100 MHz clk, package cycle counts
// Notes:   counters stand in for long intervals
`timescale 1ns/1ps
`default_nettype none
module ufat_chk #(
   parameter int ERASE_CYCLES = 50,
   parameter int HV_CYCLES    = 100
) (
   input wire logic                         clk,
   input wire logic                         rst_n,
   input wire logic                         wake,
   input wire logic                         req_valid,
   input wire ufat_pkg::ufat_req_t          req,
   input wire logic                         req_ready,
   input wire logic                         done,
   input wire logic                         refused,
   input wire logic                         hv_overrun,
   input wire logic [ufat_pkg::DAT_W-1:0]   rdata,
   input wire ufat_pkg::ufat_pins_t         pins,
   input wire logic [ufat_pkg::DAT_W-1:0]   flash_dout
);
   import ufat_pkg::*;
   int up_c;
   int en_c;
   int sp_c;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_c <= 0;
         en_c <= 0;
         sp_c <= 0;
      end else begin
         up_c <= pins.power_down ? 0 : up_c + 1;
         en_c <= (pins.prog_enable || pins.erase_enable) ? en_c + 1 : 0;
         sp_c <= pins.sense_strobe ? sp_c + 1 : 0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_wake; $rose(req_ready) |-> up_c >= WK_CYC - 1; endproperty
   a_wake: assert property (p_wake) else $error("ready before wake-up");
   property p_setup;
      $rose(pins.sense_strobe) && !pins.prog_enable |->
         $past(pins.row_enable, 2) && $past(pins.column_enable, 2);
   endproperty
   a_setup: assert property (p_setup) else $error("strobe before setup");
   property p_hold;
      $rose(pins.sense_strobe) && !pins.prog_enable |-> (pins.sense_strobe && pins.row_enable
         && pins.column_enable && $stable(pins.row_address)
         && $stable(pins.column_address))[*3];
   endproperty
   a_hold: assert property (p_hold) else $error("read hold too short");
   property p_nvs; $rose(pins.storage_enable) |-> en_c >= NVS_CYC; endproperty
   a_nvs: assert property (p_nvs) else $error("storage setup short");
   property p_pulse;
      $fell(pins.sense_strobe) && $past(pins.prog_enable) |-> sp_c >= 800 && sp_c <= 1600;
   endproperty
   a_pulse: assert property (p_pulse) else $error("program pulse width");
   property p_erase; $fell(pins.erase_enable) |-> en_c >= ERASE_CYCLES; endproperty
   a_erase: assert property (p_erase) else $error("erase too short");
   property p_rdata; !$stable(rdata) |-> $fell(pins.sense_strobe); endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved");
   property p_refuse; refused |-> (!pins.prog_enable && !pins.sense_strobe)[*4]; endproperty
   a_refuse: assert property (p_refuse) else $error("refused but programmed");
   property p_hv;
      hv_overrun && !(req_valid && req_ready && req.op == OP_MASS) |=> hv_overrun;
   endproperty
   a_hv: assert property (p_hv) else $error("overrun flag dropped");
endmodule
bind ufat_ctrl ufat_chk #(.ERASE_CYCLES(ERASE_CYCLES), .HV_CYCLES(HV_CYCLES)) u_chk (
   .clk(clk), .rst_n(rst_n), .wake(wake), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .done(done), .refused(refused), .hv_overrun(hv_overrun),
   .rdata(rdata), .pins(pins), .flash_dout(flash_dout));
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench for the flash sequencer
// Assumes: erase shortened to 50 cycles, storage age to 100
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ufat_pkg::*;
   logic             clk, rst_n, wake, req_valid, req_ready, done, refused, hv_overrun;
   logic             got_ref;
   ufat_req_t        req;
   ufat_pins_t       pins;
   logic [DAT_W-1:0] rdata, flash_dout;
   int               miscompares = 0;
   int               compares = 0;
   int               cycles = 0;
   ufat_ctrl #(.ERASE_CYCLES(50), .HV_CYCLES(100)) dut (.clk(clk), .rst_n(rst_n),
      .wake(wake), .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
      .refused(refused), .hv_overrun(hv_overrun), .rdata(rdata), .pins(pins),
      .flash_dout(flash_dout));
   ufat_flash_model u_flash (.pins(pins), .dout(flash_dout));
   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", s, e, g);
         miscompares++;
      end
   endtask
   task automatic run(input logic [1:0] o, input logic [8:0] r, input logic [5:0] c,
                      input logic [31:0] d);
      int n = 0;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      req_valid = 1'b1;
      req = '{o, r, c, d};
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && refused !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      got_ref = refused;
      chk("completion", 1, n < 20000);
   endtask
   task automatic rd(input logic [8:0] r, input logic [5:0] c, input logic [31:0] e);
      run(OP_READ, r, c, 32'h0);
      chk("read data", e, rdata);
   endtask
   task automatic t_wake;
      repeat (600) @(negedge clk);
      chk("ready in wake-up", 0, req_ready);
      chk("overrun at start", 0, hv_overrun);
      $display("wake test done");
   endtask
   task automatic t_prog_read;
      run(OP_PROG, 9'h005, 6'h0A, 32'hA5A51234);
      run(OP_PROG, 9'h1FF, 6'h3F, 32'h0F0F0F0F);
      rd(9'h005, 6'h0A, 32'hA5A51234);
      repeat (50) @(negedge clk);
      chk("read data held", 32'hA5A51234, rdata);
      rd(9'h1FF, 6'h3F, 32'h0F0F0F0F);
      rd(9'h005, 6'h0B, 32'hFFFFFFFF);
      $display("program and read test done");
   endtask
   task automatic t_reprogram;
      run(OP_PROG, 9'h005, 6'h0A, 32'h11111111);
      chk("second program refused", 1, got_ref);
      rd(9'h005, 6'h0A, 32'hA5A51234);
      $display("reprogram test done");
   endtask
   task automatic t_erase;
      run(OP_PAGE, 9'h005, 6'h00, 32'h0);
      rd(9'h005, 6'h0A, 32'hFFFFFFFF);
      rd(9'h1FF, 6'h3F, 32'h0F0F0F0F);
      run(OP_PROG, 9'h005, 6'h0A, 32'h22222222);
      chk("program after erase", 0, got_ref);
      rd(9'h005, 6'h0A, 32'h22222222);
      chk("storage age overrun", 1, hv_overrun);
      run(OP_MASS, 9'h000, 6'h00, 32'h0);
      chk("storage age cleared", 0, hv_overrun);
      rd(9'h1FF, 6'h3F, 32'hFFFFFFFF);
      run(OP_PROG, 9'h1FF, 6'h3F, 32'h33333333);
      chk("program after mass erase", 0, got_ref);
      $display("erase test done");
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      rst_n = 1'b0;
      wake = 1'b0;
      req_valid = 1'b0;
      req = '0;
      got_ref = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      t_wake();
      t_prog_read();
      t_reprogram();
      t_erase();
      print_verdict();
   end
endmodule
`default_nettype wire
